// *** hdl/rfd_pkg.sv ***
// package: register map, field positions, reset values and types for the rail decoder
package rfd_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] RFD_ADDR_ENABLE = 4'h0;
  localparam logic [3:0] RFD_ADDR_PINS = 4'h1;
  localparam logic [3:0] RFD_ADDR_STATUS = 4'h2;
  localparam logic [3:0] RFD_ADDR_ID = 4'h3;
  // enable register fields
  localparam int RFD_BIT_TX_LDO = 0;
  localparam int RFD_BIT_PA_SW = 1;
  localparam int RFD_BIT_RX_LDO = 2;
  localparam int RFD_BIT_LNA_SW = 3;
  localparam int RFD_BIT_ANA_LDO = 4;
  localparam int RFD_EN_WIDTH = 5;
  localparam logic [4:0] RFD_EN_RESET = 5'h14;
  // identity value is arbitrary
  localparam logic [31:0] RFD_ID_VALUE = 32'h00005a01;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RFD_RAIL_OFF = 2'h0,
    RFD_RAIL_NORMAL = 2'h1,
    RFD_RAIL_LOW_POWER = 2'h2
  } rfd_rail_type;
  typedef struct packed {
    logic tx_ldo_enable_bit;
    logic pa_switch_enable_bit;
    logic rx_ldo_enable_bit;
    logic lna_switch_enable_bit;
    logic analog_ldo_enable_bit;
  } rfd_enable_type;
  typedef struct packed {
    logic master_enable;
    logic io_supply_present;
    logic chip_reset_input;
    logic rf_on_pin;
    logic tx_on_fast_pin;
  } rfd_pins_type;
  typedef struct packed {
    logic tx_rail;
    logic pa_supply_switch;
    rfd_rail_type rx_rail;
    logic lna_supply_switch;
    rfd_rail_type analog_rail;
  } rfd_rails_type;
endpackage : rfd_pkg

// *** hdl/rfd_sync.sv ***
// two-flop synchroniser for one pin
module rfd_sync (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // pin level in, synchronised level out
  input wire logic async_i,
  output logic sync_o
);
  logic stage1;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : rfd_sync

// *** hdl/rfd_rail_decode.sv ***
// rail enable decoder with avalon-mm enable register
// Summary of operation
// - tx regulator on when all four enables high
// - tx regulator enable bit writable, resets 0
// - pa switch closes with six inputs high
// - pa switch gated by tx regulator on
// - pa switch enable bit writable, resets 0
// - rx regulator off unless bit, master, io
// - rx mode follows rf pin; reset forces normal
// - rx regulator enable bit writable, resets 1
// - lna switch closes with five inputs high
// - lna switch enable bit writable, resets 0
// - analog regulator off unless bit, master, io
// - analog mode follows rf pin; reset forces normal
// - analog regulator enable bit writable, resets 1
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
module rfd_rail_decode (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // pins from the system
  input wire rfd_pkg::rfd_pins_type pins_i,
  // rail controls
  output rfd_pkg::rfd_rails_type rails_o
);
  import rfd_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPINS = $bits(rfd_pins_type);
  logic [NPINS-1:0] pins_raw;
  logic [NPINS-1:0] pins_syn;
  rfd_pins_type pins;
  assign pins_raw = pins_i;
  assign pins = pins_syn;

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_sync
      rfd_sync u_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(pins_raw[gi]),
        .sync_o(pins_syn[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  // single-cycle answer: read data registered, waitrequest high for the first request cycle
  logic [RFD_EN_WIDTH-1:0] enable_bits;
  rfd_enable_type en;
  logic req_done;
  logic [31:0] next_readdata;
  logic [31:0] readdata;
  wire sel_enable = avs_address_i == RFD_ADDR_ENABLE;
  wire sel_pins = avs_address_i == RFD_ADDR_PINS;
  wire sel_status = avs_address_i == RFD_ADDR_STATUS;
  wire sel_id = avs_address_i == RFD_ADDR_ID;
  wire req = avs_read_i | avs_write_i;
  wire accept = req & ~req_done;
  // write lands at the edge where the master sees waitrequest low
  wire wr_enable = req_done & avs_write_i & sel_enable & avs_byteenable_i[0];
  // fields picked by index: the struct's packing order differs from the register bit map
  assign en.tx_ldo_enable_bit = enable_bits[RFD_BIT_TX_LDO];
  assign en.pa_switch_enable_bit = enable_bits[RFD_BIT_PA_SW];
  assign en.rx_ldo_enable_bit = enable_bits[RFD_BIT_RX_LDO];
  assign en.lna_switch_enable_bit = enable_bits[RFD_BIT_LNA_SW];
  assign en.analog_ldo_enable_bit = enable_bits[RFD_BIT_ANA_LDO];

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_done <= 1'b0;
    end else begin
      req_done <= accept;
    end
  end

  // accept cycle raises waitrequest; the write lands in the following cycle
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_bits <= RFD_EN_RESET;
    end else if (wr_enable) begin
      enable_bits <= avs_writedata_i[RFD_EN_WIDTH-1:0];
    end
  end

  // unmapped addresses read zero and ignore writes
  assign next_readdata = sel_enable ? {27'h0, enable_bits} :
                         sel_pins ? {27'h0, pins_syn} :
                         sel_status ? {25'h0, rails_o} :
                         sel_id ? RFD_ID_VALUE : 32'h0;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      readdata <= 32'h0;
    end else if (accept) begin
      readdata <= next_readdata;
    end
  end

  assign avs_readdata_o = readdata;
  assign avs_waitrequest_o = req & ~req_done;

  // ----------------------------------------------------------------
  // rail decode
  // ----------------------------------------------------------------
  // the host keeps battery-low policy itself; no battery sensing here
  wire supply_ok = pins.master_enable & pins.io_supply_present;
  wire next_tx_on = supply_ok & pins.rf_on_pin & en.tx_ldo_enable_bit;
  wire next_pa_on = next_tx_on & pins.tx_on_fast_pin & en.pa_switch_enable_bit;
  wire rx_en = supply_ok & en.rx_ldo_enable_bit;
  wire next_lna_on = rx_en & pins.rf_on_pin & en.lna_switch_enable_bit;
  wire ana_en = supply_ok & en.analog_ldo_enable_bit;
  // chip reset low overrides the rf pin and keeps full performance
  wire normal_sel = ~pins.chip_reset_input | pins.rf_on_pin;
  rfd_rail_type next_rx_mode;
  rfd_rail_type next_ana_mode;
  assign next_rx_mode = !rx_en ? RFD_RAIL_OFF : normal_sel ? RFD_RAIL_NORMAL : RFD_RAIL_LOW_POWER;
  assign next_ana_mode = !ana_en ? RFD_RAIL_OFF : normal_sel ? RFD_RAIL_NORMAL : RFD_RAIL_LOW_POWER;

  // one register stage keeps the rail controls glitch free
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rails_o <= '{tx_rail: 1'b0, pa_supply_switch: 1'b0, rx_rail: RFD_RAIL_OFF,
                   lna_supply_switch: 1'b0, analog_rail: RFD_RAIL_OFF};
    end else begin
      rails_o.tx_rail <= next_tx_on;
      rails_o.pa_supply_switch <= next_pa_on;
      rails_o.rx_rail <= next_rx_mode;
      rails_o.lna_supply_switch <= next_lna_on;
      rails_o.analog_rail <= next_ana_mode;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_tx_on_cond: assert property (rails_o.tx_rail == $past(next_tx_on) || $past(!reset_n_i))
    else $error("tx rail does not match its enables");
  chk_tx_reset_off: assert property ($rose(reset_n_i) |-> !en.tx_ldo_enable_bit)
    else $error("tx enable bit not cleared by reset");
  chk_pa_gated_tx: assert property (rails_o.pa_supply_switch |-> rails_o.tx_rail)
    else $error("pa switch closed with tx rail off");
  chk_pa_needs_fast: assert property (rails_o.pa_supply_switch |-> $past(pins.tx_on_fast_pin && en.pa_switch_enable_bit))
    else $error("pa switch closed without fast pin and bit");
  chk_pa_en_reset: assert property ($rose(reset_n_i) |-> !en.pa_switch_enable_bit && !en.lna_switch_enable_bit)
    else $error("switch enable bits not cleared by reset");
  chk_rx_off_cond: assert property (!rx_en |=> rails_o.rx_rail == RFD_RAIL_OFF)
    else $error("rx rail on without enables");
  chk_rx_mode_sel: assert property (rx_en && pins.chip_reset_input && !pins.rf_on_pin |=> rails_o.rx_rail == RFD_RAIL_LOW_POWER)
    else $error("rx low power mode not selected");
  chk_rx_force_norm: assert property (rx_en && !pins.chip_reset_input |=> rails_o.rx_rail == RFD_RAIL_NORMAL)
    else $error("rx normal mode not forced in chip reset");
  chk_rx_ana_default: assert property ($rose(reset_n_i) |-> en.rx_ldo_enable_bit && en.analog_ldo_enable_bit)
    else $error("rx or analog enable bit not set by reset");
  chk_lna_cond: assert property (rails_o.lna_supply_switch |-> $past(rx_en && pins.rf_on_pin && en.lna_switch_enable_bit))
    else $error("lna switch closed without its enables");
  chk_ana_off_cond: assert property (!ana_en |=> rails_o.analog_rail == RFD_RAIL_OFF)
    else $error("analog rail on without enables");
  chk_ana_mode_sel: assert property (ana_en |=> rails_o.analog_rail == ($past(normal_sel) ? RFD_RAIL_NORMAL : RFD_RAIL_LOW_POWER))
    else $error("analog mode wrong");
  chk_write_lands: assert property (wr_enable |=> enable_bits == $past(avs_writedata_i[RFD_EN_WIDTH-1:0]) ##1 rails_o.tx_rail == $past(next_tx_on))
    else $error("enable write not applied");

  cov_pa_on: cover property (rails_o.pa_supply_switch);
  cov_lna_on: cover property (rails_o.lna_supply_switch);
  cov_rx_low: cover property (rails_o.rx_rail == RFD_RAIL_LOW_POWER);
  cov_ana_low_to_norm: cover property (rails_o.analog_rail == RFD_RAIL_LOW_POWER ##1 rails_o.analog_rail == RFD_RAIL_NORMAL);
endmodule : rfd_rail_decode

// *** tb/rfd_bb_model.sv ***
// baseband controller model: avalon-mm master and rf timing pins
module rfd_bb_model (
  // clock
  input wire logic core_clk_i,
  // avalon-mm master
  output logic [3:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i,
  // timing pins
  output rfd_pkg::rfd_pins_type pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import rfd_pkg::*;
  initial begin
    {avs_address_o, avs_read_o, avs_write_o, avs_writedata_o, avs_byteenable_o} = '0;
    pins_o = '0;
  end
  // waitrequest is sampled at the rising edge before the slave's updates land
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge core_clk_i);
    avs_address_o <= a;
    avs_write_o <= wr;
    avs_read_o <= !wr;
    avs_writedata_o <= d;
    avs_byteenable_o <= be;
    do @(posedge core_clk_i); while (avs_waitrequest_i !== 1'b0);
    q = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
  endtask : bus
  task automatic set_pins(input rfd_pins_type p);
    @(posedge core_clk_i);
    pins_o <= p;
  endtask : set_pins
  // weak battery: host drops every rail it owns
  task automatic battery_low(output logic [31:0] q);
    bus(1'b1, RFD_ADDR_ENABLE, 32'h0, 4'hf, q);
  endtask : battery_low
endmodule : rfd_bb_model

// *** tb/tb.sv ***
// testbench: rail decode tables and enable register access
`define RFD_CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rfd_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] address;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic waitreq;
  rfd_pins_type pins;
  rfd_rails_type rails;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] q;
  always #5 core_clk_i = ~core_clk_i;
  rfd_rail_decode u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .avs_address_i(address),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .pins_i(pins), .rails_o(rails));
  rfd_bb_model u_bb (.core_clk_i(core_clk_i), .avs_address_o(address), .avs_read_o(rd),
    .avs_write_o(wr), .avs_writedata_o(wdata), .avs_byteenable_o(be), .avs_readdata_i(rdata),
    .avs_waitrequest_i(waitreq), .pins_o(pins));
  function automatic rfd_rails_type model(input rfd_pins_type p, input logic [4:0] e);
    rfd_rails_type r;
    logic up;
    up = p.master_enable & p.io_supply_present;
    r.tx_rail = up & p.rf_on_pin & e[RFD_BIT_TX_LDO];
    r.pa_supply_switch = r.tx_rail & p.tx_on_fast_pin & e[RFD_BIT_PA_SW];
    r.rx_rail = !(up & e[RFD_BIT_RX_LDO]) ? RFD_RAIL_OFF :
      (!p.chip_reset_input | p.rf_on_pin) ? RFD_RAIL_NORMAL : RFD_RAIL_LOW_POWER;
    r.lna_supply_switch = up & p.rf_on_pin & e[RFD_BIT_RX_LDO] & e[RFD_BIT_LNA_SW];
    r.analog_rail = !(up & e[RFD_BIT_ANA_LDO]) ? RFD_RAIL_OFF :
      (!p.chip_reset_input | p.rf_on_pin) ? RFD_RAIL_NORMAL : RFD_RAIL_LOW_POWER;
    return r;
  endfunction : model
  // pins take two sync flops plus the output register
  task automatic settle();
    repeat (3) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : settle
  task automatic test_reset();
    u_bb.bus(1'b0, RFD_ADDR_ENABLE, 32'h0, 4'hf, q);
    `RFD_CHECK(q, 32'h00000014)
    settle();
    `RFD_CHECK(rails, model(5'h1f, 5'h14))
    $display("test reset done");
  endtask : test_reset
  task automatic test_tables();
    for (int e = 0; e < 32; e++) begin
      u_bb.bus(1'b1, RFD_ADDR_ENABLE, 32'(e), 4'h1, q);
      u_bb.bus(1'b0, RFD_ADDR_ENABLE, 32'h0, 4'hf, q);
      `RFD_CHECK(q, 32'(e))
      for (int p = 0; p < 32; p++) begin
        u_bb.set_pins(5'(p));
        settle();
        `RFD_CHECK(rails, model(5'(p), 5'(e)))
      end
    end
    $display("test tables done");
  endtask : test_tables
  task automatic test_refused();
    u_bb.bus(1'b1, RFD_ADDR_ENABLE, 32'h0000000b, 4'he, q);
    u_bb.bus(1'b1, 4'h9, 32'hffffffff, 4'hf, q);
    u_bb.bus(1'b0, 4'h9, 32'h0, 4'hf, q);
    `RFD_CHECK(q, 32'h0)
    u_bb.bus(1'b0, RFD_ADDR_ENABLE, 32'h0, 4'hf, q);
    `RFD_CHECK(q, 32'h0000001f)
    $display("test refused done");
  endtask : test_refused
  task automatic test_battery();
    u_bb.battery_low(q);
    settle();
    `RFD_CHECK(rails, model(5'h1f, 5'h00))
    $display("test battery done");
  endtask : test_battery
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    u_bb.set_pins(5'h1f);
    repeat (20) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    test_reset();
    test_tables();
    test_refused();
    test_battery();
    end_of_test();
  end
endmodule : tb
